// ### kscfg_top.sv
// Key slot configuration, destination check and AHB key export.
// Assumes Avalon-MM master, a hardware key source and an AHB5 subordinate.
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
module kscfg_top
   import kscfg_pkg::*;
#(
   parameter int              NSLOTS        = 8,
   parameter logic [3:0]      HW_SLOTS      = 4'h2,
   parameter logic [15:0]     TARGET_NIBS   = 16'h0004,
   parameter logic            MASK_PRESENT  = 1'b1,
   parameter logic [15:0]     MASK_BITS     = 16'hFFFF,
   parameter logic [NSLOTS*32-1:0] SLOT_CFG_RV  = '0,
   parameter logic [NSLOTS*32-1:0] DEST_ADDR_RV = '0
) (
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   input  wire logic [7:0]       i_avs_address,
   input  wire logic             i_avs_read,
   input  wire logic             i_avs_write,
   input  wire logic [31:0]      i_avs_writedata,
   input  wire logic [3:0]       i_avs_byteenable,
   output logic      [31:0]      o_avs_readdata,
   output logic                  o_avs_waitrequest,
   input  wire logic             i_hwkey_valid,
   input  wire logic [31:0]      i_hwkey_data,
   input  wire logic             i_hready,
   output kscfg_pkg::kscfg_ahb_s o_ahb,
   output logic                  o_alarm,
   output logic                  o_irq
);
   import kscfg_pkg::*;

   localparam int AW = $clog2(NSLOTS);

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   function automatic logic nib_match(input logic [3:0] nib);
      logic m;
      m = 1'b0;
      for (int g = 0; g < KSCFG_NIB_GROUPS; g++) begin
         if (TARGET_NIBS[g*KSCFG_NIB_W +: KSCFG_NIB_W] != 4'h0 &&
             TARGET_NIBS[g*KSCFG_NIB_W +: KSCFG_NIB_W] == nib) begin
            m = 1'b1;
         end
      end
      return m;
   endfunction

   function automatic logic is_hw(input logic [AW-1:0] s);
      return {1'b0, s} < {1'b0, HW_SLOTS[AW:0]};
   endfunction

   // Slot windows hold NSLOTS words; the rest of each window reads zero
   function automatic logic slot_hit(input logic [7:0] a, input logic [7:0] base);
      return a[7:6] == base[7:6] && a[5:2] < 4'(NSLOTS);
   endfunction

   wire logic          acc      = (i_avs_read | i_avs_write) & o_avs_waitrequest;
   wire logic          wr       = i_avs_write & o_avs_waitrequest;
   wire logic [AW-1:0] sel      = i_avs_address[2 +: AW];
   wire logic          cfg_hit  = slot_hit(i_avs_address, KSCFG_OFF_SLOTCFG);
   wire logic          dst_hit  = slot_hit(i_avs_address, KSCFG_OFF_DEST);
   wire logic          wr_cfg   = wr && cfg_hit;
   wire logic          wr_dst   = wr && dst_hit;
   wire logic          wr_status = wr && i_avs_address == KSCFG_OFF_STATUS;
   wire logic          wr_mask  = wr && i_avs_address == KSCFG_OFF_MASK;
   wire logic          wr_cmd   = wr && i_avs_address == KSCFG_OFF_CMD;
   wire logic          wr_key   = wr && i_avs_address == KSCFG_OFF_KEYWORD;
   wire logic          dst_ok   = nib_match(i_avs_writedata[31:28]);
   wire logic [AW-1:0] cmd_slot = i_avs_writedata[AW-1:0];

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [31:0]          slot_cfg_reg [NSLOTS];
   logic [31:0]          dest_reg     [NSLOTS];
   logic [NSLOTS-1:0]    valid_reg;
   logic [3:0]           hw_fill_reg;
   logic [KSCFG_IRQ_W-1:0] status_reg;
   logic [KSCFG_IRQ_W-1:0] mask_reg;
   logic [AW-1:0]        exp_slot_reg;
   kscfg_state_e         state_reg;
   logic [31:0]          key_rdata;

   wire logic [AW-1:0] sel_key    = i_avs_writedata[AW-1:0];
   wire logic          hw_fill_ok = i_hwkey_valid && hw_fill_reg < HW_SLOTS;
   // A software load that meets a hardware fill is dropped, so no slot turns valid empty
   wire logic          sw_key_ok  = wr_key && !hw_fill_ok && !is_hw(sel_key) &&
                                    !slot_cfg_reg[sel_key][KSCFG_LOCK_BIT];

   generate
      for (genvar s = 0; s < NSLOTS; s++) begin : g_slot
         wire logic locked = slot_cfg_reg[s][KSCFG_LOCK_BIT];
         wire logic [31:0] cfg_wr_val = MASK_PRESENT ?
              i_avs_writedata :
              (i_avs_writedata | (32'h1 << KSCFG_WMD_BIT));
         wire logic [31:0] cfg_rv = MASK_PRESENT ?
              SLOT_CFG_RV[s*32 +: 32] :
              (SLOT_CFG_RV[s*32 +: 32] | (32'h1 << KSCFG_WMD_BIT));
         wire logic [31:0] cfg_next = locked ? slot_cfg_reg[s] : cfg_wr_val;

         always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               slot_cfg_reg[s] <= cfg_rv;
            end else if (wr_cfg && sel == AW'(s)) begin
               slot_cfg_reg[s] <= cfg_next;
            end
         end

         always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               dest_reg[s] <= DEST_ADDR_RV[s*32 +: 32];
            end else if (wr_dst && sel == AW'(s) && dst_ok && !locked) begin
               dest_reg[s] <= i_avs_writedata;
            end
         end

         // Hardware fill ranks above software set and invalidate
         always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               valid_reg[s] <= 1'b0;
            end else if (hw_fill_ok && hw_fill_reg == 4'(s)) begin
               valid_reg[s] <= 1'b1;
            end else if (sw_key_ok && sel_key == AW'(s)) begin
               valid_reg[s] <= 1'b1;
            end else if (wr_cmd && i_avs_writedata[KSCFG_CMD_INVAL] && cmd_slot == AW'(s)) begin
               valid_reg[s] <= 1'b0;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Hardware key fill pointer and key memory
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         hw_fill_reg <= 4'h0;
      end else if (hw_fill_ok) begin
         hw_fill_reg <= hw_fill_reg + 4'h1;
      end
   end

   // Software key value comes from a holding word written beforehand
   logic [31:0] key_hold_reg;

   // Hardware port wins the memory write
   wire logic          mem_we    = hw_fill_ok | sw_key_ok;
   wire logic [AW-1:0] mem_waddr = hw_fill_ok ? hw_fill_reg[AW-1:0] : sel_key;
   wire logic [31:0]   mem_wdata = hw_fill_ok ? i_hwkey_data : key_hold_reg;

   kscfg_keymem #(.DEPTH(NSLOTS), .AW(AW)) u_mem (
      .i_clk   (i_clk),
      .i_we    (mem_we),
      .i_waddr (mem_waddr),
      .i_wdata (mem_wdata),
      .i_raddr (exp_slot_reg),
      .o_rdata (key_rdata)
   );

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         key_hold_reg <= KSCFG_ZERO32;
      end else if (wr && i_avs_address == KSCFG_OFF_HWKEY) begin
         key_hold_reg <= i_avs_writedata;
      end
   end

   // ------------------------------------------------------------
   // Export engine
   // ------------------------------------------------------------
   wire logic start = wr_cmd && i_avs_writedata[KSCFG_CMD_EXPORT] &&
                      valid_reg[cmd_slot] && state_reg == KSCFG_IDLE;
   wire logic reject = wr_cmd && i_avs_writedata[KSCFG_CMD_EXPORT] && !start;
   wire logic [31:0] exp_addr = dest_reg[exp_slot_reg];
   // Mask bits ride along whenever the filter is built in
   wire logic [15:0] exp_mask = MASK_PRESENT ? MASK_BITS : 16'h0000;

   // Slot latched once at start and held for the whole transfer
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         exp_slot_reg <= '0;
      end else if (start) begin
         exp_slot_reg <= cmd_slot;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_reg <= KSCFG_IDLE;
         o_ahb     <= '0;
      end else begin
         case (state_reg)
            KSCFG_IDLE: begin
               o_ahb.htrans <= KSCFG_HTRANS_IDLE;
               if (start) begin
                  state_reg <= KSCFG_ADDR;
               end
            end
            KSCFG_ADDR: begin
               // One cycle for registered key read before address phase
               o_ahb.htrans  <= KSCFG_HTRANS_NSEQ;
               o_ahb.haddr   <= exp_addr;
               o_ahb.hwrite  <= 1'b1;
               o_ahb.hsize   <= KSCFG_HSIZE_WORD;
               o_ahb.hprot   <= {KSCFG_HPROT_HI, KSCFG_HPROT_LO};
               o_ahb.hnonsec <= KSCFG_SECURE;
               state_reg     <= KSCFG_DATA;
            end
            KSCFG_DATA: begin
               if (o_ahb.htrans == KSCFG_HTRANS_NSEQ && i_hready) begin
                  o_ahb.htrans <= KSCFG_HTRANS_IDLE;
                  o_ahb.hwdata <= key_rdata;
                  o_ahb.hwuser <= {^key_rdata, exp_mask};
               end else if (o_ahb.htrans == KSCFG_HTRANS_IDLE && i_hready) begin
                  state_reg <= KSCFG_IDLE;
               end
            end
            default: state_reg <= KSCFG_IDLE;
         endcase
      end
   end

   wire logic exp_done = state_reg == KSCFG_DATA && o_ahb.htrans == KSCFG_HTRANS_IDLE &&
                         i_hready;

   // ------------------------------------------------------------
   // Interrupts and alarm
   // ------------------------------------------------------------
   wire logic addr_bad = wr_dst && !dst_ok;
   wire logic [KSCFG_IRQ_W-1:0] events = {reject, addr_bad, exp_done};
   wire logic [KSCFG_IRQ_W-1:0] status_next =
        (status_reg & ~(wr_status ? i_avs_writedata[KSCFG_IRQ_W-1:0] : '0)) | events;

   wire logic [KSCFG_IRQ_W-1:0] mask_next =
        wr_mask ? i_avs_writedata[KSCFG_IRQ_W-1:0] : mask_reg;

   // Set wins over a clear in the same cycle, so no event is lost
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         status_reg <= '0;
      end else begin
         status_reg <= status_next;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mask_reg <= '0;
      end else begin
         mask_reg <= mask_next;
      end
   end

   // Built from next values, so the pin follows the registers without lag
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(status_next & mask_next);
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_alarm <= 1'b0;
      end else begin
         o_alarm <= status_next[KSCFG_IRQ_ADDR];
      end
   end

   // ------------------------------------------------------------
   // Read mux and waitrequest
   // ------------------------------------------------------------
   wire logic [31:0] build_val = {27'h0, MASK_PRESENT, HW_SLOTS};
   logic [31:0] rd_val;

   always_comb begin
      rd_val = KSCFG_ZERO32;
      case (i_avs_address)
         KSCFG_OFF_BUILD: begin
            rd_val = build_val;
         end
         KSCFG_OFF_STATUS: begin
            rd_val = {29'h0, status_reg};
         end
         KSCFG_OFF_MASK: begin
            rd_val = {29'h0, mask_reg};
         end
         KSCFG_OFF_CMD: begin
            rd_val = {16'h0, 8'(hw_fill_reg), 6'h0, state_reg != KSCFG_IDLE, 1'b0};
         end
         default: begin
            if (cfg_hit) begin
               rd_val = slot_cfg_reg[sel];
            end else if (dst_hit) begin
               rd_val = dest_reg[sel];
            end
         end
      endcase
   end

   // One wait state: a request is taken while waitrequest is still high
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_avs_waitrequest <= 1'b1;
      end else begin
         o_avs_waitrequest <= ~acc;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_avs_readdata <= KSCFG_ZERO32;
      end else if (acc && i_avs_read) begin
         o_avs_readdata <= rd_val;
      end
   end

endmodule

// ### kscfg_pkg.sv
// Package for the key slot export configuration block.
// Assumes a single 20 MHz clock domain and Avalon-MM software access.
package kscfg_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] KSCFG_OFF_BUILD   = 8'h00;
   localparam logic [7:0] KSCFG_OFF_STATUS  = 8'h04;
   localparam logic [7:0] KSCFG_OFF_MASK    = 8'h08;
   localparam logic [7:0] KSCFG_OFF_CMD     = 8'h0C;
   localparam logic [7:0] KSCFG_OFF_KEYWORD = 8'h10;
   localparam logic [7:0] KSCFG_OFF_SLOTCFG = 8'h40;
   localparam logic [7:0] KSCFG_OFF_DEST    = 8'h80;
   localparam logic [7:0] KSCFG_OFF_HWKEY   = 8'hC0;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int KSCFG_BC_HWCNT_LSB = 0;
   localparam int KSCFG_BC_MFP_BIT   = 4;
   localparam int KSCFG_WMD_BIT      = 21;
   localparam int KSCFG_LOCK_BIT     = 0;
   localparam int KSCFG_CMD_EXPORT   = 8;
   localparam int KSCFG_CMD_INVAL    = 9;
   localparam int KSCFG_NIB_W        = 4;
   localparam int KSCFG_NIB_GROUPS   = 4;

   // Interrupt status bits
   localparam int KSCFG_IRQ_DONE   = 0;
   localparam int KSCFG_IRQ_ADDR   = 1;
   localparam int KSCFG_IRQ_REJECT = 2;
   localparam int KSCFG_IRQ_W      = 3;

   // ------------------------------------------------------------
   // AHB attribute constants
   // ------------------------------------------------------------
   localparam logic [3:0] KSCFG_HPROT_LO   = 4'h3;
   localparam logic [2:0] KSCFG_HPROT_HI   = 3'h0;
   localparam logic [1:0] KSCFG_HTRANS_IDLE = 2'h0;
   localparam logic [1:0] KSCFG_HTRANS_NSEQ = 2'h2;
   localparam logic [2:0] KSCFG_HSIZE_WORD = 3'h2;
   localparam logic       KSCFG_SECURE     = 1'b0;

   localparam logic [31:0] KSCFG_ZERO32 = 32'h0000_0000;

   typedef struct packed {
      logic [1:0]  htrans;
      logic [31:0] haddr;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [6:0]  hprot;
      logic        hnonsec;
      logic [31:0] hwdata;
      logic [16:0] hwuser;
   } kscfg_ahb_s;

   typedef enum logic [1:0] {KSCFG_IDLE, KSCFG_ADDR, KSCFG_DATA} kscfg_state_e;

endpackage

// ### kscfg_keymem.sv
// Key word memory for all slots, one word per slot.
// Assumes one write port and registered read data.
`timescale 1ns/10ps
module kscfg_keymem #(
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire logic          i_clk,
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [31:0]   i_wdata,
   input  wire logic [AW-1:0] i_raddr,
   output logic      [31:0]   o_rdata
);
   logic [31:0] mem [DEPTH];

   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule

// ### kscfg_top_assertions.sv
// Port-level checker for kscfg_top.
// Assumes it is bound into kscfg_top; one clock, async reset.
`timescale 1ns/10ps
module kscfg_top_assertions
   import kscfg_pkg::*;
#(
   parameter int          NSLOTS       = 8,
   parameter logic [3:0]  HW_SLOTS     = 4'h2,
   parameter logic [15:0] TARGET_NIBS  = 16'h0004,
   parameter logic        MASK_PRESENT = 1'b1,
   parameter logic [15:0] MASK_BITS    = 16'hFFFF
) (
   input wire logic                  i_clk,
   input wire logic                  i_sys_rst,
   input wire logic [7:0]            i_avs_address,
   input wire logic                  i_avs_read,
   input wire logic                  i_avs_write,
   input wire logic [31:0]           i_avs_writedata,
   input wire logic [31:0]           o_avs_readdata,
   input wire logic                  o_avs_waitrequest,
   input wire logic                  i_hready,
   input wire kscfg_pkg::kscfg_ahb_s o_ahb,
   input wire logic                  o_alarm
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   logic       dest_wr;
   logic       nib_ok;
   logic       busy_ahb;
   logic       dph_reg;
   logic [3:0] top;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   assign top      = i_avs_writedata[31:28];
   assign busy_ahb = o_ahb.htrans != KSCFG_HTRANS_IDLE;
   assign dest_wr  = i_avs_write && o_avs_waitrequest && i_avs_address >= KSCFG_OFF_DEST
                     && i_avs_address < KSCFG_OFF_DEST + 8'(4 * NSLOTS);
   // Zero groups are unimplemented, so they are kept out of the match
   assign nib_ok   = (TARGET_NIBS[3:0] != 4'h0 && TARGET_NIBS[3:0] == top)
                     || (TARGET_NIBS[7:4] != 4'h0 && TARGET_NIBS[7:4] == top)
                     || (TARGET_NIBS[11:8] != 4'h0 && TARGET_NIBS[11:8] == top)
                     || (TARGET_NIBS[15:12] != 4'h0 && TARGET_NIBS[15:12] == top);
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst)
         dph_reg <= 1'b0;
      else if (i_hready)
         dph_reg <= o_ahb.htrans == KSCFG_HTRANS_NSEQ;
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   bad_dest_a: assert property (dest_wr && !nib_ok |-> ##[1:3] o_alarm)
      else $error("no alarm after rejected destination write");
   zero_group_a: assert property (dest_wr && top == 4'h0 |-> ##[1:3] o_alarm)
      else $error("zero top nibble was accepted");
   good_dest_a: assert property (dest_wr && nib_ok && !o_alarm |=> !o_alarm [*2])
      else $error("alarm after matching destination write");
   build_read_a: assert property (
      i_avs_read && o_avs_waitrequest && i_avs_address == KSCFG_OFF_BUILD
      |=> o_avs_readdata[4:0] == {MASK_PRESENT, HW_SLOTS})
      else $error("build configuration read wrong");
   write_only_a: assert property (o_ahb.htrans == KSCFG_HTRANS_NSEQ |-> o_ahb.hwrite)
      else $error("export transfer is not a write");
   prot_low_a: assert property (busy_ahb |-> o_ahb.hprot[3:0] == 4'h3)
      else $error("export protection low bits wrong");
   secure_xfer_a: assert property (busy_ahb |-> !o_ahb.hnonsec)
      else $error("export transfer not secure");
   prot_high_a: assert property (busy_ahb |-> o_ahb.hprot[6:4] == 3'h0)
      else $error("export extended protection bits not zero");
   user_mask_a: assert property (
      MASK_PRESENT && dph_reg && i_hready |-> o_ahb.hwuser[15:0] == MASK_BITS)
      else $error("mask bits missing from user signals");
   parity_bit_a: assert property (dph_reg && i_hready |-> o_ahb.hwuser[16] == ^o_ahb.hwdata)
      else $error("parity bit on user signals wrong");
endmodule

// ### kscfg_ahb_sub.sv
// Model of the subordinate that receives exported keys.
// Assumes single write transfers and the clock of kscfg_top.
`timescale 1ns/10ps
module kscfg_ahb_sub
   import kscfg_pkg::*;
(
   input  wire logic                  i_clk,
   input  wire logic                  i_sys_rst,
   input  wire logic                  i_slow,
   input  wire kscfg_pkg::kscfg_ahb_s i_ahb,
   output logic                       o_hready,
   output logic [7:0]                 o_cnt,
   output logic [31:0]                o_addr,
   output logic [31:0]                o_data,
   output logic [16:0]                o_user
);
   // Slow mode stalls three cycles of four; reads are never counted
   logic        dph_reg;
   logic [1:0]  ph_reg;
   logic [31:0] a_reg;
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_hready <= 1'b1;
         dph_reg  <= 1'b0;
         ph_reg   <= 2'h0;
         a_reg    <= 32'h0;
         o_cnt    <= 8'h00;
         o_addr   <= 32'h0;
         o_data   <= 32'h0;
         o_user   <= 17'h0;
      end else begin
         ph_reg   <= ph_reg + 2'h1;
         o_hready <= !i_slow || ph_reg == 2'h3;
         if (o_hready) begin
            dph_reg <= i_ahb.htrans == KSCFG_HTRANS_NSEQ && i_ahb.hwrite;
            a_reg   <= i_ahb.haddr;
            if (dph_reg) begin
               o_cnt  <= o_cnt + 8'h01;
               o_addr <= a_reg;
               o_data <= i_ahb.hwdata;
               o_user <= i_ahb.hwuser;
            end
         end
      end
   end
endmodule

// ### kscfg_top_tb.sv
// Self-checking bench for kscfg_top with a subordinate model.
// Assumes package, design, model and checker compile first.
`timescale 1ns/10ps
module kscfg_top_tb;
   import kscfg_pkg::*;
   // ------------------------------------------------------------
   // Setup
   // ------------------------------------------------------------
   localparam logic [15:0]  NIBS   = 16'hCA04;
   localparam logic [15:0]  MBITS  = 16'h5A3C;
   localparam logic [255:0] CFG_RV = {224'h0, 32'h0020_0000};
   localparam logic [255:0] DST_RV = {192'h0, 32'hA000_0020, 32'h4000_0010};
   logic        i_clk = 1'b0;
   logic        rst = 1'b1;
   logic        av_rd = 1'b0;
   logic        av_wr = 1'b0;
   logic        hk_vld = 1'b0;
   logic        slow = 1'b0;
   logic [7:0]  av_a = 8'h00;
   logic [31:0] av_d = 32'h0;
   logic [31:0] hk_d = 32'h0;
   logic [31:0] q, d, e, rdata, p_addr, p_data;
   logic [31:0] k [4];
   logic [16:0] p_user;
   logic [7:0]  cnt;
   logic        wreq, hready, alarm, irq;
   kscfg_ahb_s  ahb;
   int          n_errors = 0;
   int          n_compared = 0;
   int          seed = 43669;
   int          i;
   always #25 i_clk = ~i_clk;
   kscfg_top #(.HW_SLOTS(4'h2), .TARGET_NIBS(NIBS), .MASK_BITS(MBITS), .SLOT_CFG_RV(CFG_RV),
      .DEST_ADDR_RV(DST_RV)) dut (.i_clk, .i_sys_rst(rst), .i_avs_address(av_a),
      .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_d), .i_avs_byteenable(4'hF),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_hwkey_valid(hk_vld),
      .i_hwkey_data(hk_d), .i_hready(hready), .o_ahb(ahb), .o_alarm(alarm), .o_irq(irq));
   kscfg_ahb_sub u_sub (.i_clk, .i_sys_rst(rst), .i_slow(slow), .i_ahb(ahb), .o_hready(hready),
      .o_cnt(cnt), .o_addr(p_addr), .o_data(p_data), .o_user(p_user));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dd);
      int n;
      n = 0;
      @(posedge i_clk);
      av_wr <= wr;
      av_rd <= !wr;
      av_a  <= a;
      av_d  <= dd;
      @(posedge i_clk);
      while (wreq !== 1'b0 && n < 50) begin
         @(posedge i_clk);
         n++;
      end
      if (n == 50)
         n_errors++;
      q = rdata;
      av_wr <= 1'b0;
      av_rd <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q & m, exp);
   endtask
   // Waits on the model's count, so a lost export times out here
   task automatic xport(input logic [2:0] s, input logic [31:0] a, input logic [31:0] key);
      logic [7:0] c0;
      int         n;
      c0 = cnt;
      n = 0;
      bus(1'b1, KSCFG_OFF_CMD, 32'h0000_0100 | 32'(s));
      while (cnt === c0 && n < 300) begin
         @(posedge i_clk);
         n++;
      end
      if (n == 300)
         n_errors++;
      chk(p_addr, a);
      chk(p_data, key);
      chk({16'h0, p_user[15:0]}, {16'h0, MBITS});
      chk({31'h0, p_user[16]}, {31'h0, ^key});
   endtask
   function automatic logic nib_ok(input logic [3:0] t);
      nib_ok = 1'b0;
      for (int g = 0; g < 4; g++)
         if (NIBS[4*g +: 4] != 4'h0 && NIBS[4*g +: 4] == t)
            nib_ok = 1'b1;
   endfunction
   task automatic conclude;
      if (n_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      conclude();
   end
   initial begin
      repeat (10) @(posedge i_clk);
      rst <= 1'b0;
      rd(KSCFG_OFF_BUILD, 32'h1F, 32'h12);
      for (i = 0; i < 8; i++) begin
         rd(KSCFG_OFF_SLOTCFG + 8'(4*i), '1, CFG_RV[32*i +: 32]);
         rd(KSCFG_OFF_DEST + 8'(4*i), '1, DST_RV[32*i +: 32]);
      end
      rd(8'h20, '1, 32'h0);
      e = 32'h0;
      for (i = 0; i < 16; i++) begin
         d = {i[3:0], 28'($random(seed))};
         bus(1'b1, KSCFG_OFF_DEST + 8'h08, d);
         if (nib_ok(i[3:0]))
            e = d;
         rd(KSCFG_OFF_DEST + 8'h08, '1, e);
         chk({31'h0, alarm}, {31'h0, !nib_ok(i[3:0])});
         bus(1'b1, KSCFG_OFF_STATUS, 32'h0000_0002);
      end
      bus(1'b1, KSCFG_OFF_SLOTCFG + 8'h08, 32'h0020_0000);
      rd(KSCFG_OFF_SLOTCFG + 8'h08, 32'h0020_0001, 32'h0020_0000);
      bus(1'b1, KSCFG_OFF_SLOTCFG + 8'h08, 32'h0000_0001);
      bus(1'b1, KSCFG_OFF_SLOTCFG + 8'h08, 32'h0020_0000);
      rd(KSCFG_OFF_SLOTCFG + 8'h08, 32'h0020_0001, 32'h0000_0001);
      for (i = 0; i < 4; i++)
         k[i] = $random(seed);
      for (i = 0; i < 2; i++) begin
         @(posedge i_clk);
         hk_vld <= 1'b1;
         hk_d   <= k[i];
         @(posedge i_clk);
         hk_vld <= 1'b0;
      end
      bus(1'b1, KSCFG_OFF_HWKEY, k[2]);
      bus(1'b1, KSCFG_OFF_KEYWORD, 32'h0);
      bus(1'b1, KSCFG_OFF_HWKEY, k[3]);
      bus(1'b1, KSCFG_OFF_KEYWORD, 32'h3);
      bus(1'b1, KSCFG_OFF_DEST + 8'h0C, 32'hC000_0100);
      bus(1'b1, KSCFG_OFF_MASK, 32'h1);
      xport(3'h0, 32'h4000_0010, k[0]);
      slow <= 1'b1;
      xport(3'h1, 32'hA000_0020, k[1]);
      xport(3'h3, 32'hC000_0100, k[3]);
      rd(KSCFG_OFF_STATUS, 32'h7, 32'h1);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, KSCFG_OFF_MASK, 32'h0);
      rd(KSCFG_OFF_MASK, '1, 32'h0);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, KSCFG_OFF_MASK, 32'h1);
      bus(1'b1, KSCFG_OFF_STATUS, 32'h1);
      rd(KSCFG_OFF_STATUS, 32'h7, 32'h0);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, KSCFG_OFF_CMD, 32'h0000_0201);
      bus(1'b1, KSCFG_OFF_CMD, 32'h0000_0101);
      rd(KSCFG_OFF_STATUS, 32'h7, 32'h4);
      conclude();
   end
endmodule
bind kscfg_top kscfg_top_assertions #(.NSLOTS(NSLOTS), .HW_SLOTS(HW_SLOTS),
   .TARGET_NIBS(TARGET_NIBS), .MASK_PRESENT(MASK_PRESENT), .MASK_BITS(MASK_BITS)) u_chk (
   .i_clk, .i_sys_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
   .o_avs_readdata, .o_avs_waitrequest, .i_hready, .o_ahb, .o_alarm);
